//--- hdl/mcs_fifo.sv
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module mcs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;
   // pointers and fill count
   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      wr_d = push ? ((wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1) : wr_q;
      rd_d = pop ? ((rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1) : rd_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end
   // storage has no reset; only valid entries are ever read
   always_ff @(posedge clock) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
endmodule : mcs_fifo

//--- hdl/mcs_host.sv
// host end: two-wire master driving commands, read bytes queued in a fifo
`timescale 1ns/1ps
module mcs_host (
   input wire logic clock,
   input wire logic rst_n,
   mcs_if.host bus,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [1:0] cmd_kind,
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] cmd_data,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [7:0] rd_data,
   output logic busy,
   output logic nack_seen
);
   typedef enum logic [2:0] {
      MCH_IDLE = 3'b000,
      MCH_START = 3'b001,
      MCH_BYTE = 3'b010,
      MCH_STOP = 3'b011,
      MCH_WAIT = 3'b100
   } mch_state_t;
   mch_state_t st_q, st_d;
   logic [mcs_pkg::HCNT_W-1:0] tm_q, tm_d;
   logic [1:0] ph_q, ph_d;
   logic [3:0] bit_q, bit_d;
   logic [1:0] seq_q, seq_d, kind_q, kind_d;
   logic [7:0] sh_q, sh_d, rx_q, rx_d, ad_q, ad_d, dt_q, dt_d;
   logic scl_q, scl_d, oe_q, oe_d, nk_q, nk_d, push;
   logic [1:0] sda_s_q;
   logic tick, fifo_rdy;
   // kind 0 byte write, 1 current read, 2 random read
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sda_s_q <= 2'h3;
      end else begin
         sda_s_q <= {sda_s_q[0], bus.sda};
      end
   end
   assign tick = (tm_q == '0);
   // sequencer: each half bit is split into two phases of the divider
   always_comb begin
      st_d = st_q;
      tm_d = tick ? mcs_pkg::HCNT_W'(mcs_pkg::HALF_CYC / 2) : tm_q - 1'b1;
      ph_d = ph_q;
      bit_d = bit_q;
      seq_d = seq_q;
      kind_d = kind_q;
      sh_d = sh_q;
      rx_d = rx_q;
      ad_d = ad_q;
      dt_d = dt_q;
      scl_d = scl_q;
      oe_d = oe_q;
      nk_d = nk_q;
      push = 1'b0;
      case (st_q)
         MCH_IDLE: begin
            if (cmd_valid && fifo_rdy) begin
               kind_d = cmd_kind;
               ad_d = cmd_addr;
               dt_d = cmd_data;
               seq_d = '0;
               nk_d = 1'b0;
               ph_d = '0;
               st_d = MCH_START;
            end
         end
         MCH_START: if (tick) begin
            // release, raise clock, pull data low, lower clock
            ph_d = ph_q + 2'h1;
            case (ph_q)
               2'h0: oe_d = 1'b0;
               2'h1: scl_d = 1'b1;
               2'h2: oe_d = 1'b1;
               default: begin
                  scl_d = 1'b0;
                  bit_d = '0;
                  sh_d = {mcs_pkg::DEV_TYPE, mcs_pkg::SEL_TIED,
                          (kind_q == 2'h1) || (seq_q == 2'h2)};
                  st_d = MCH_BYTE;
               end
            endcase
         end
         MCH_BYTE: if (tick) begin
            ph_d = ph_q + 2'h1;
            case (ph_q)
               2'h0: begin
                  // data set while clock low; release for rx and ack
                  if (bit_q == 4'h8) begin
                     oe_d = (seq_q == 2'h3) ? !nk_q : 1'b0;
                  end else begin
                     oe_d = (seq_q == 2'h3) ? 1'b0 : !sh_q[7];
                  end
               end
               2'h1: scl_d = 1'b1;
               2'h2: begin
                  if (bit_q != 4'h8) begin
                     rx_d = {rx_q[6:0], sda_s_q[1]};
                  end else if (seq_q != 2'h3 && sda_s_q[1]) begin
                     nk_d = 1'b1;
                  end
               end
               default: begin
                  scl_d = 1'b0;
                  bit_d = bit_q + 4'h1;
                  sh_d = {sh_q[6:0], 1'b0};
                  if (bit_q == 4'h8) begin
                     st_d = MCH_WAIT;
                  end
               end
            endcase
         end
         MCH_WAIT: begin
            // pick the next byte of the command or finish
            bit_d = '0;
            ph_d = '0;
            // a refused byte ends the command; our own read nack does not
            if (nk_q && seq_q != 2'h3) begin
               st_d = MCH_STOP;
            end else if (seq_q == 2'h0 && kind_q != 2'h1) begin
               seq_d = 2'h1;
               sh_d = ad_q;
               rx_d = ad_q;
               st_d = MCH_BYTE;
            end else if (seq_q == 2'h1 && kind_q == 2'h0) begin
               seq_d = 2'h2;
               sh_d = dt_q;
               st_d = MCH_BYTE;
            end else if (seq_q == 2'h1) begin
               seq_d = 2'h2;
               st_d = MCH_START;
            end else if ((seq_q == 2'h0 && kind_q == 2'h1) ||
                         (seq_q == 2'h2 && kind_q == 2'h2)) begin
               seq_d = 2'h3;
               nk_d = 1'b1;
               sh_d = 8'h01;
               st_d = MCH_BYTE;
            end else begin
               if (seq_q == 2'h3) begin
                  nk_d = 1'b0;
                  push = 1'b1;
               end
               st_d = MCH_STOP;
            end
         end
         MCH_STOP: if (tick) begin
            ph_d = ph_q + 2'h1;
            case (ph_q)
               2'h0: oe_d = 1'b1;
               2'h1: scl_d = 1'b1;
               2'h2: oe_d = 1'b0;
               default: st_d = MCH_IDLE;
            endcase
         end
         default: st_d = MCH_IDLE;
      endcase
   end
   // bytes leave msb first; seq 3 marks the one received byte
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st_q <= MCH_IDLE;
         tm_q <= '0;
         ph_q <= '0;
         bit_q <= '0;
         seq_q <= '0;
         kind_q <= '0;
         sh_q <= '0;
         rx_q <= '0;
         ad_q <= '0;
         dt_q <= '0;
         scl_q <= 1'b1;
         oe_q <= 1'b0;
         nk_q <= 1'b0;
      end else begin
         st_q <= st_d;
         tm_q <= tm_d;
         ph_q <= ph_d;
         bit_q <= bit_d;
         seq_q <= seq_d;
         kind_q <= kind_d;
         sh_q <= sh_d;
         rx_q <= rx_d;
         ad_q <= ad_d;
         dt_q <= dt_d;
         scl_q <= scl_d;
         oe_q <= oe_d;
         nk_q <= nk_d;
      end
   end
   // read bytes wait here; a full fifo holds off new commands
   mcs_fifo #(.WIDTH(mcs_pkg::DATA_W), .DEPTH(mcs_pkg::FIFO_DEPTH))
      mcs_fifo_inst (
      .clock(clock),
      .rst_n(rst_n),
      .in_valid(push),
      .in_ready(fifo_rdy),
      .in_data(rx_q),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(rd_data)
   );
   assign cmd_ready = (st_q == MCH_IDLE) && fifo_rdy;
   assign bus.scl = scl_q;
   assign bus.sda_m_oe = oe_q;
   assign busy = (st_q != MCH_IDLE);
   assign nack_seen = nk_q;
endmodule : mcs_host

//--- hdl/mcs_if.sv
// two-wire link between the host master and the configuration store
`timescale 1ns/1ps
interface mcs_if;
   logic scl;
   logic sda_m_oe;
   logic sda_s_oe;
   logic sda;
   // open drain: any party that enables pulls the wire low
   assign sda = ~(sda_m_oe | sda_s_oe);
   modport store (input scl, input sda, output sda_s_oe);
   modport host (output scl, input sda, output sda_m_oe);
endinterface : mcs_if

//--- hdl/mcs_pkg.sv
// shared constants for the two-wire configuration store link
package mcs_pkg;
   localparam logic [3:0] DEV_TYPE = 4'hA; // arbitrary device-type code
   localparam logic [2:0] SEL_TIED = 3'h0;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 8;
   localparam logic [7:0] MEM_TOP = 8'hFF;
   localparam logic RW_READ = 1'b1;
   localparam logic RW_WRITE = 1'b0;
   // bus timing, half clock period in ns and in system clock cycles
   localparam int CLK_NS = 25;
   localparam int HALF_NS = 5000;
   localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam int HCNT_W = 8;
endpackage : mcs_pkg

//--- hdl/mcs_store.sv
// configuration store end: two-wire slave with 256-byte memory
// Operation
// - data changes only while clock low
// - start opens command; idle until start
// - stop ends command, returns to standby
// - transmitter releases; receiver acks ninth clock
// - match address, ack, then read/write
// - read: release, sample ack, next byte
// - no ack after read byte stops transmit
// - write: ack each byte until stop
// - upper four address bits are type code
// - three select bits from tied-low pins
// - last address bit: one read, zero write
// - counter holds last location plus one
// - current read: ack, eight bits, stop
// - random read uses dummy write, restart
// - data line driven open drain only
// - all shifting timed by serial clock
// - read counter wraps from top to zero
`timescale 1ns/1ps
module mcs_store (
   input wire logic clock,
   input wire logic rst_n,
   mcs_if.store bus,
   input wire logic select_pin_bit0,
   input wire logic select_pin_bit1,
   input wire logic select_pin_bit2,
   output logic [7:0] wr_addr,
   output logic [7:0] wr_data,
   output logic wr_strobe
);
   typedef enum logic [2:0] {
      MCS_IDLE = 3'b000,
      MCS_DEVADR = 3'b001,
      MCS_WORD = 3'b010,
      MCS_WDATA = 3'b011,
      MCS_RDATA = 3'b100,
      MCS_ACKOUT = 3'b101,
      MCS_ACKIN = 3'b110
   } mcs_state_t;
   logic [1:0] scl_s_q, sda_s_q;
   logic scl_q, sda_q;
   logic scl_rise, scl_fall, start_ev, stop_ev;
   mcs_state_t st_q, st_d, ret_q, ret_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d, cnt_q, cnt_d;
   logic oe_q, oe_d, rw_q, rw_d, wr_q, wr_d;
   logic [7:0] wa_q, wa_d, wd_q, wd_d;
   logic [7:0] mem_q [256];
   logic [6:0] own_addr;
   logic [2:0] sel_s1_q, sel_s2_q;
   // strap pins pass the same two flops as the wire before compare
   assign own_addr = {mcs_pkg::DEV_TYPE, sel_s2_q};
   // two-flop synchronisers, then a registered copy for edge finding
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         sel_s1_q <= mcs_pkg::SEL_TIED;
         sel_s2_q <= mcs_pkg::SEL_TIED;
      end else begin
         scl_s_q <= {scl_s_q[0], bus.scl};
         sda_s_q <= {sda_s_q[0], bus.sda};
         scl_q <= scl_s_q[1];
         sda_q <= sda_s_q[1];
         sel_s1_q <= {select_pin_bit2, select_pin_bit1, select_pin_bit0};
         sel_s2_q <= sel_s1_q;
      end
   end
   assign scl_rise = scl_s_q[1] && !scl_q;
   assign scl_fall = !scl_s_q[1] && scl_q;
   // data moving while clock high is framing, never data
   assign start_ev = scl_s_q[1] && scl_q && sda_q && !sda_s_q[1];
   assign stop_ev = scl_s_q[1] && scl_q && !sda_q && sda_s_q[1];
   // protocol sequencer: sample on rising clock, drive on falling clock
   always_comb begin
      st_d = st_q;
      ret_d = ret_q;
      bit_d = bit_q;
      sh_d = sh_q;
      cnt_d = cnt_q;
      oe_d = oe_q;
      rw_d = rw_q;
      wr_d = 1'b0;
      wa_d = wa_q;
      wd_d = wd_q;
      if (stop_ev) begin
         st_d = MCS_IDLE;
         oe_d = 1'b0;
      end else if (start_ev) begin
         st_d = MCS_DEVADR;
         bit_d = '0;
         oe_d = 1'b0;
      end else begin
         case (st_q)
            MCS_IDLE: begin
               oe_d = 1'b0;
            end
            MCS_DEVADR, MCS_WORD, MCS_WDATA: begin
               if (scl_rise) begin
                  sh_d = {sh_q[6:0], sda_s_q[1]};
                  bit_d = bit_q + 4'h1;
               end
               if (scl_fall && bit_q == 4'h8) begin
                  bit_d = '0;
                  if (st_q == MCS_DEVADR) begin
                     if (sh_q[7:1] == own_addr) begin
                        rw_d = sh_q[0];
                        oe_d = 1'b1;
                        st_d = MCS_ACKOUT;
                        ret_d = (sh_q[0] == mcs_pkg::RW_READ) ?
                                MCS_RDATA : MCS_WORD;
                     end else begin
                        st_d = MCS_IDLE;
                     end
                  end else if (st_q == MCS_WORD) begin
                     cnt_d = sh_q;
                     oe_d = 1'b1;
                     st_d = MCS_ACKOUT;
                     ret_d = MCS_WDATA;
                  end else begin
                     wa_d = cnt_q;
                     wd_d = sh_q;
                     wr_d = 1'b1;
                     cnt_d = cnt_q + 8'h01;
                     oe_d = 1'b1;
                     st_d = MCS_ACKOUT;
                     ret_d = MCS_WDATA;
                  end
               end
            end
            MCS_ACKOUT: begin
               // hold ack through the ninth clock; on its fall release, or drive the first bit of a read byte
               if (scl_fall) begin
                  st_d = ret_q;
                  bit_d = '0;
                  if (ret_q == MCS_RDATA) begin
                     sh_d = mem_q[cnt_q];
                     oe_d = !mem_q[cnt_q][7];
                  end else begin
                     oe_d = 1'b0;
                  end
               end
            end
            MCS_RDATA: begin
               if (scl_rise) begin
                  bit_d = bit_q + 4'h1;
               end
               if (scl_fall) begin
                  if (bit_q == 4'h8) begin
                     oe_d = 1'b0;
                     cnt_d = cnt_q + 8'h01;
                     st_d = MCS_ACKIN;
                  end else begin
                     sh_d = {sh_q[6:0], 1'b0};
                     oe_d = !sh_q[6];
                  end
               end
            end
            MCS_ACKIN: begin
               if (scl_rise) begin
                  if (sda_s_q[1]) begin
                     st_d = MCS_IDLE;
                  end else begin
                     st_d = MCS_ACKOUT;
                     ret_d = MCS_RDATA;
                  end
               end
            end
            default: begin
               st_d = MCS_IDLE;
            end
         endcase
      end
   end
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st_q <= MCS_IDLE;
         ret_q <= MCS_IDLE;
         bit_q <= '0;
         sh_q <= '0;
         cnt_q <= '0;
         oe_q <= 1'b0;
         rw_q <= 1'b0;
         wr_q <= 1'b0;
         wa_q <= '0;
         wd_q <= '0;
      end else begin
         st_q <= st_d;
         ret_q <= ret_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         cnt_q <= cnt_d;
         oe_q <= oe_d;
         rw_q <= rw_d;
         wr_q <= wr_d;
         wa_q <= wa_d;
         wd_q <= wd_d;
      end
   end
   // memory, written one cycle after the byte is taken
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         for (int i = 0; i < 256; i++) begin
            mem_q[i] <= '0;
         end
      end else if (wr_q) begin
         mem_q[wa_q] <= wd_q;
      end
   end
   assign bus.sda_s_oe = oe_q;
   assign wr_addr = wa_q;
   assign wr_data = wd_q;
   assign wr_strobe = wr_q;
endmodule : mcs_store

//--- tb/mcs_props.sv
// protocol checker for the two-wire link between host and store
`timescale 1ns/1ps
module mcs_props (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic sda_m_oe,
   input wire logic sda_s_oe,
   input wire logic sda
);
   logic scl_q, sda_q, first_q, first_d, rd_q, rd_d;
   logic [3:0] bit_q, bit_d;
   logic rise, start, stop;
   // wire events as seen by the system clock
   assign rise = scl && !scl_q;
   assign start = scl && scl_q && sda_q && !sda;
   assign stop = scl && scl_q && !sda_q && sda;
   // bit position; a nack on a read byte ends the read phase
   always_comb begin
      bit_d = bit_q;
      first_d = first_q;
      rd_d = rd_q;
      if (start) begin
         bit_d = 4'h0;
         first_d = 1'h1;
         rd_d = 1'h0;
      end else if (rise && bit_q == 4'h8) begin
         bit_d = 4'h0;
         first_d = 1'h0;
         if (rd_q && !first_q && sda) rd_d = 1'h0;
      end else if (rise) begin
         bit_d = bit_q + 4'h1;
         if (bit_q == 4'h7 && first_q) rd_d = sda;
      end
   end
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         scl_q <= 1'h1;
         sda_q <= 1'h1;
         bit_q <= 4'h0;
         first_q <= 1'h0;
         rd_q <= 1'h0;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         bit_q <= bit_d;
         first_q <= first_d;
         rd_q <= rd_d;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence start_seq; start; endsequence
   sequence stop_seq; stop; endsequence
   sequence nack_seq;
      rise && bit_q == 4'h8 && rd_q && !first_q && sda;
   endsequence
   slave_high_stable_a: assert property (
      scl && $past(scl) |-> $stable(sda_s_oe))
      else $error("store data moved with clock high");
   start_hold_a: assert property (start_seq |=> scl [*8])
      else $error("clock fell right after start");
   stop_idle_a: assert property (stop_seq |=> !sda_s_oe [*8])
      else $error("store drives after stop");
   addr_ack_a: assert property (
      rise && bit_q == 4'h8 && first_q |-> sda_s_oe)
      else $error("own address not acknowledged");
   write_ack_a: assert property (
      rise && bit_q == 4'h8 && !rd_q |-> sda_s_oe && !sda_m_oe)
      else $error("written byte not acknowledged by store");
   read_release_a: assert property (
      rise && bit_q == 4'h8 && rd_q && !first_q |-> !sda_s_oe)
      else $error("store holds data line on ninth clock");
   read_quiet_a: assert property (
      rise && rd_q && !first_q && bit_q < 4'h8 |-> !sda_m_oe)
      else $error("host drives during read data bits");
   recv_quiet_a: assert property (
      rise && !rd_q && bit_q < 4'h8 |-> !sda_s_oe)
      else $error("store drives while receiving");
   nack_release_a: assert property (
      nack_seq |=> !sda_s_oe throughout (##[1:1000] stop_seq))
      else $error("store not released until stop after nack");
endmodule : mcs_props

//--- tb/presence_detect_serial_slave_test.sv
// testbench joining host and store ends over the two-wire link
`timescale 1ns/1ps
module presence_detect_serial_slave_test;
   logic clock, rst_n, cmd_valid, cmd_ready, rd_valid, rd_ready, busy;
   logic nack_seen, wr_strobe, mscl, msda;
   logic [1:0] cmd_kind;
   logic [2:0] sel_b;
   logic [7:0] cmd_addr, cmd_data, rd_data, wr_addr, wr_data, wa_q, wd_q, msh;
   logic [7:0] wire_q[$];
   int err_count = 0;
   int samples_checked = 0;
   int wr_cnt = 0;
   int mbit = 0;
   mcs_if bus ();
   mcs_if bus_b ();
   mcs_host mcs_host_inst (.clock(clock), .rst_n(rst_n), .bus(bus.host),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .rd_data(rd_data), .busy(busy),
      .nack_seen(nack_seen));
   mcs_store mcs_store_inst (.clock(clock), .rst_n(rst_n), .bus(bus.store),
      .select_pin_bit0(1'h0), .select_pin_bit1(1'h0),
      .select_pin_bit2(1'h0), .wr_addr(wr_addr), .wr_data(wr_data),
      .wr_strobe(wr_strobe));
   // second store faced by a hand-driven master that breaks the rules
   mcs_store mcs_store_inst_b (.clock(clock), .rst_n(rst_n),
      .bus(bus_b.store), .select_pin_bit0(sel_b[0]),
      .select_pin_bit1(sel_b[1]), .select_pin_bit2(sel_b[2]),
      .wr_addr(), .wr_data(), .wr_strobe());
   mcs_props mcs_props_inst (.clock(clock), .rst_n(rst_n), .scl(bus.scl),
      .sda_m_oe(bus.sda_m_oe), .sda_s_oe(bus.sda_s_oe), .sda(bus.sda));
   initial begin
      clock = 1'h0;
      forever #12.5 clock = ~clock;
   end
   // wire monitor: bytes msb first, plus the last stored byte and a store count
   always @(posedge clock) begin
      if (bus.scl && mscl && msda && !bus.sda) mbit = 0;
      else if (bus.scl && !mscl) begin
         msh = {msh[6:0], bus.sda};
         mbit++;
         if (mbit == 8) wire_q.push_back(msh);
         if (mbit == 9) mbit = 0;
      end
      mscl = bus.scl;
      msda = bus.sda;
      if (wr_strobe === 1'h1) begin
         wa_q = wr_addr;
         wd_q = wr_data;
         wr_cnt++;
      end
   end
   task automatic check(input string nm, input logic [7:0] seen,
                        input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude
   task automatic chk_wire(input logic [7:0] e[$]);
      logic [7:0] got;
      check("wire byte count", 8'(wire_q.size()), 8'(e.size()));
      foreach (e[i]) begin
         got = (i < wire_q.size()) ? wire_q[i] : 8'hXX;
         check("wire byte", got, e[i]);
      end
      wire_q.delete();
   endtask : chk_wire
   // one command through the handshake, then wait for the link to go idle
   task automatic run_cmd(input logic [1:0] k, input logic [7:0] a,
                          input logic [7:0] d);
      int n;
      cmd_valid <= 1'h1;
      cmd_kind <= k;
      cmd_addr <= a;
      cmd_data <= d;
      n = 0;
      // ready is looked at mid-cycle; the command goes at the next edge
      @(negedge clock);
      while (cmd_ready !== 1'h1 && n < 1000) begin
         @(negedge clock);
         n++;
      end
      check("command taken", {7'h0, cmd_ready}, 8'h1);
      @(posedge clock);
      cmd_valid <= 1'h0;
      repeat (2) @(posedge clock);
      n = 0;
      while (busy !== 1'h0 && n < 40000) begin
         @(negedge clock);
         n++;
      end
      check("command finished", {7'h0, busy}, 8'h0);
      check("host nack flag", {7'h0, nack_seen}, 8'h0);
      @(posedge clock);
   endtask : run_cmd
   // stalls the reader first, so the fifo must keep offering the byte
   task automatic take_read(input logic [7:0] e, input string nm);
      int n;
      logic [7:0] held;
      n = 0;
      while (rd_valid !== 1'h1 && n < 1000) begin
         @(negedge clock);
         n++;
      end
      held = rd_data;
      repeat (50) @(negedge clock);
      check("read offered", {7'h0, rd_valid}, 8'h1);
      check("read held", rd_data, held);
      check(nm, rd_data, e);
      @(posedge clock);
      rd_ready <= 1'h1;
      @(posedge clock);
      rd_ready <= 1'h0;
      @(negedge clock);
      check("read drained", {7'h0, rd_valid}, 8'h0);
      @(posedge clock);
   endtask : take_read
   // bench link clock: 200 ns period, four system cycles per half
   localparam int LINK_HALF = 4;
   task automatic half;
      repeat (LINK_HALF) @(posedge clock);
   endtask : half
   task automatic b_start;
      bus_b.sda_m_oe <= 1'h1;
      half;
      bus_b.scl <= 1'h0;
      half;
   endtask : b_start
   task automatic b_stop;
      bus_b.sda_m_oe <= 1'h1;
      half;
      bus_b.scl <= 1'h1;
      half;
      bus_b.sda_m_oe <= 1'h0;
      half;
   endtask : b_stop
   // data moves half way through the low phase, never with the clock
   task automatic b_byte(input logic [7:0] b, input logic ack,
                         input string nm);
      for (int i = 7; i >= 0; i--) begin
         bus_b.sda_m_oe <= ~b[i];
         repeat (LINK_HALF / 2) @(posedge clock);
         bus_b.scl <= 1'h1;
         half;
         bus_b.scl <= 1'h0;
         repeat (LINK_HALF / 2) @(posedge clock);
      end
      bus_b.sda_m_oe <= 1'h0;
      repeat (LINK_HALF / 2) @(posedge clock);
      bus_b.scl <= 1'h1;
      half;
      check(nm, {7'h0, bus_b.sda}, {7'h0, ~ack});
      bus_b.scl <= 1'h0;
      half;
   endtask : b_byte
   task automatic t_write_pair;
      run_cmd(2'h0, 8'h00, 8'hC3);
      check("stored address", wa_q, 8'h00);
      check("stored data", wd_q, 8'hC3);
      chk_wire('{8'hA0, 8'h00, 8'hC3});
      run_cmd(2'h0, 8'hFF, 8'h5A);
      check("stored top address", wa_q, 8'hFF);
      check("stored top data", wd_q, 8'h5A);
      check("store count", 8'(wr_cnt), 8'h02);
      check("idle clock", {7'h0, bus.scl}, 8'h1);
      check("idle data", {7'h0, bus.sda}, 8'h1);
      wire_q.delete();
   endtask : t_write_pair
   task automatic t_random_read;
      run_cmd(2'h2, 8'hFF, 8'h00);
      chk_wire('{8'hA0, 8'hFF, 8'hA1, 8'h5A});
      check("dummy write stores nothing", 8'(wr_cnt), 8'h02);
      take_read(8'h5A, "random read data");
   endtask : t_random_read
   task automatic t_wrap_read;
      run_cmd(2'h1, 8'h00, 8'h00);
      chk_wire('{8'hA1, 8'hC3});
      take_read(8'hC3, "wrapped current read");
   endtask : t_wrap_read
   task automatic t_foreign;
      b_start;
      b_byte(8'h50, 1'h0, "foreign type code");
      b_byte(8'hA0, 1'h0, "address without start");
      b_stop;
      b_start;
      b_byte(8'hA2, 1'h0, "wrong select bits");
      b_stop;
      sel_b <= 3'h1;
      b_start;
      b_byte(8'hA2, 1'h1, "matching select bits");
      b_stop;
      check("released line", {7'h0, bus_b.sda}, 8'h1);
   endtask : t_foreign
   initial begin
      rst_n = 1'h0;
      cmd_valid = 1'h0;
      cmd_kind = 2'h0;
      cmd_addr = 8'h00;
      cmd_data = 8'h00;
      rd_ready = 1'h0;
      sel_b = 3'h0;
      bus_b.scl = 1'h1;
      bus_b.sda_m_oe = 1'h0;
      repeat (10) @(posedge clock);
      rst_n <= 1'h1;
      t_write_pair;
      t_random_read;
      t_wrap_read;
      t_foreign;
      conclude;
   end
   // watchdog well beyond the expected run of about 50000 cycles
   initial begin
      repeat (95000) @(posedge clock);
      err_count++;
      $display("ERROR watchdog expired before the tests ended");
      conclude;
   end
endmodule : presence_detect_serial_slave_test
